// ===== logic/loop_map.svh
// Field sizes, check polynomial, rate divisors and timing counts for the loop link
`ifndef LOOP_MAP_SVH
`define LOOP_MAP_SVH
`define SYNC_BITS 4
`define CRC_BITS 8
`define CRC_POLY 8'h07
`define SHORT_BYTES 10
`define LONG_BYTES 12
`define OS_PER_BIT 16
`define PULSE_OS (`OS_PER_BIT / 2)
`define ZRUN 6
`define SUB_HOLD 4
`define RATE_DIV_4K 64
`define RATE_DIV_16K 16
`define RATE_DIV_64K 4
`define RATE_DIV_256K 1
`define HD_TIMEOUT_BITS 256
`endif

// ===== logic/loop_pkg.sv
// Types and helper functions shared by both loop ends
`include "loop_map.svh"
package loop_pkg;
  typedef enum logic [1:0] {T_WAIT, T_SYNC, T_INFO, T_CRC} tx_state_e;
  typedef enum logic [1:0] {R_HUNT, R_SYNC, R_INFO, R_CRC} rx_state_e;
  typedef enum logic [1:0] {SYM_ZERO, SYM_MARK, SYM_VIOL} sym_e;

  // One step of the serial check character
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    crc_step = {c[6:0], 1'h0} ^ ((c[7] ^ b) ? `CRC_POLY : 8'h00);
  endfunction

  // Symbol at position 0..5 of the six-zero substitution 0 V B 0 V B
  function automatic sym_e sub_sym(input logic [2:0] pos);
    case (pos)
      3'h1, 3'h4: sub_sym = SYM_VIOL;
      3'h2, 3'h5: sub_sym = SYM_MARK;
      default:    sub_sym = SYM_ZERO;
    endcase
  endfunction

  // Returns {new last polarity, positive line, negative line}
  function automatic logic [2:0] emit(input sym_e k, input logic pol);
    case (k)
      SYM_MARK: emit = {~pol, ~pol, pol};
      SYM_VIOL: emit = {pol, pol, ~pol};
      default:  emit = {pol, 2'h0};
    endcase
  endfunction
endpackage

// ===== logic/loop_if.sv
// Loop wires between the device end and the peer end
interface loop_if;
  logic tx_positive_out;
  logic tx_negative_out;
  logic rx_positive_in;
  logic rx_negative_in;
  modport device (output tx_positive_out, tx_negative_out, input rx_positive_in, rx_negative_in);
  modport peer   (input tx_positive_out, tx_negative_out, output rx_positive_in, rx_negative_in);
endinterface

// ===== logic/loop_transceiver.sv
// Device end: packet framer, line coder and receive FIFO for the loop
// Function
// [R1] Frame: 4-bit sync, 10/12 bytes, 8-bit check
// [R2] Sync tells filler frames from information frames
// [R3] First byte MSB selects voice or data port
// [R4] Check character generated and verified over field
// [R5] Sync and information bytes sent LSB first
// [R6] Check character sent MSB first
// [R7] Bit rate selectable: 4, 16, 64, 256 kb/s
// [R8] Two polarity lines each way
// [R9] Ones alternate polarity, zero sends no pulse
// [R10] Positive only +1, negative only -1, none 0
// [R11] Rate select derives 16x clock from baud clock
// [R12] Bit clock is 16x clock divided by 16
// [R13] System keeps 16x at most 4.096 MHz
// [R14] Transmit pulse lasts half a bit period
// [R15] Far pulses last 6 to 20 16x periods
// [R16] Far rising edges spaced 10 to 25 periods
// [R17] Half-duplex alternating mode and full-duplex mode
// [R18] Idle alternating link sends all-zero filler frames
// [R19] Six zeros replaced by violation pattern, restored
// [R20] Field length, rate, duplex are configuration inputs
// [R21] Reset idles framers, lines low, drops partial frame
`include "loop_map.svh"

module loop_fifo #(
  parameter int W = 10,
  parameter int D = 8
) (
  input  logic         clk_sys,
  input  logic         rst_b,
  input  logic         in_valid,
  output logic         in_ready,
  input  logic [W-1:0] in_data,
  output logic         out_valid,
  input  logic         out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } ptr_s;
  ptr_s         s_r;
  ptr_s         s_nxt;
  logic [W-1:0] mem [D];

  // Full and empty from wrap bit and index
  assign in_ready  = !((s_r.wp[AW] != s_r.rp[AW]) && (s_r.wp[AW-1:0] == s_r.rp[AW-1:0]));
  assign out_valid = (s_r.wp != s_r.rp);
  assign out_data  = mem[s_r.rp[AW-1:0]];

  // Pointer advance on each handshake
  always_comb begin
    s_nxt = s_r;
    if (in_valid && in_ready) s_nxt.wp = s_r.wp + 1'h1;
    if (out_valid && out_ready) s_nxt.rp = s_r.rp + 1'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) s_r <= '0;
    else s_r <= s_nxt;
  end

  // Storage write, no reset needed
  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) mem[s_r.wp[AW-1:0]] <= in_data;
  end
endmodule

module loop_transceiver #(
  parameter int FIFO_DEPTH = 8
) (
  input  logic         clk_sys,
  input  logic         rst_b,
  input  logic         baud_clock_in,
  input  logic [1:0]   rate_sel,
  input  logic         long_field,
  input  logic         full_duplex,
  input  logic         master,
  loop_if.device       loop,
  input  logic [7:0]   tx_data,
  input  logic         tx_valid,
  output logic         tx_ready,
  output logic [7:0]   rx_data,
  output logic         rx_last,
  output logic         voice_valid,
  input  logic         voice_ready,
  output logic         data_valid,
  input  logic         data_ready,
  output logic         crc_error
);
  typedef struct packed {
    logic                 baud_q;
    logic [6:0]           div;
    logic [3:0]           tph;
    logic                 tpos;
    logic                 tneg;
    loop_pkg::tx_state_e  tst;
    logic [6:0]           tcnt;
    logic [95:0]          tsr;
    logic [95:0]          tbuf;
    logic [3:0]           widx;
    logic                 pend;
    logic                 tx_rdy;
    logic                 tinfo;
    logic [7:0]           tcrc;
    logic [2:0]           tsub;
    logic                 tpol;
    logic [8:0]           hwait;
    logic                 hgo;
    logic                 rpq;
    logic                 rnq;
    logic [3:0]           rph;
    logic                 rmark;
    logic                 rmpol;
    logic                 rlpol;
    logic                 rvp;
    loop_pkg::rx_state_e  rxs;
    logic [6:0]           rcnt;
    logic [2:0]           rsup;
    logic                 rinfo;
    logic [95:0]          rbuf;
    logic [95:0]          dbuf;
    logic [7:0]           rcrc;
    logic [7:0]           rchk;
    logic                 dact;
    logic [3:0]           didx;
    logic                 rxdone;
    logic                 ovv;
    logic                 ovd;
    logic [7:0]           odat;
    logic                 olast;
    logic                 crc_err;
  } st_s;

  st_s                s_r;
  st_s                n;
  logic [6:0]         rate_div;
  logic [6:0]         nbits;
  logic [3:0]         nbytes;
  logic               os;
  logic               bedge;
  logic               viol;
  logic               b;
  logic [2:0]         e;
  logic [7:0]         chk;
  loop_pkg::sym_e     k;
  logic               fin_ready;
  logic               fout_valid;
  logic               fout_ready;
  logic [9:0]         fout_data;

  loop_fifo #(.W(10), .D(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (s_r.dact),
    .in_ready  (fin_ready),
    .in_data   ({s_r.dbuf[7], s_r.didx == nbytes - 4'h1, s_r.dbuf[{s_r.didx, 3'h0} +: 8]}),
    .out_valid (fout_valid),
    .out_ready (fout_ready),
    .out_data  (fout_data)
  );

  // Output stage takes a word when empty or drained
  assign fout_ready = (!s_r.ovv && !s_r.ovd) || (s_r.ovv && voice_ready) ||
                      (s_r.ovd && data_ready);

  // Rate select: baud edges per 16x tick
  // [R7] four bit rates
  always_comb begin
    case (rate_sel)
      2'h0:    rate_div = 7'(`RATE_DIV_4K);
      2'h1:    rate_div = 7'(`RATE_DIV_16K);
      2'h2:    rate_div = 7'(`RATE_DIV_64K);
      default: rate_div = 7'(`RATE_DIV_256K);
    endcase
  end

  // Next state of the whole block
  always_comb begin
    n = s_r;
    n.rxdone = 1'h0;
    n.crc_err = 1'h0;
    k = loop_pkg::SYM_ZERO;
    b = 1'h0;
    viol = 1'h0;
    e = '0;
    chk = '0;
    // [R20] length from configuration input
    nbits = long_field ? 7'(`LONG_BYTES * 8) : 7'(`SHORT_BYTES * 8);
    nbytes = long_field ? 4'(`LONG_BYTES) : 4'(`SHORT_BYTES);
    // [R11] divided baud edges give 16x tick
    bedge = baud_clock_in & ~s_r.baud_q;
    n.baud_q = baud_clock_in;
    os = bedge & (s_r.div == '0);
    if (bedge) n.div = (s_r.div == '0) ? rate_div - 7'h01 : s_r.div - 7'h01;
    // Packet bytes from the user side
    if (tx_valid && s_r.tx_rdy) begin
      n.tbuf[{s_r.widx, 3'h0} +: 8] = tx_data;
      n.widx = (s_r.widx == nbytes - 4'h1) ? 4'h0 : s_r.widx + 4'h1;
      n.pend = (s_r.widx == nbytes - 4'h1);
    end
    // [R14] pulse ends after half a bit
    if (os) begin
      n.tph = s_r.tph + 4'h1;
      if (s_r.tph == 4'(`PULSE_OS - 1)) {n.tpos, n.tneg} = 2'h0;
    end
    // [R12] slot boundary every 16 ticks
    if (os && s_r.tph == 4'(`OS_PER_BIT - 1)) begin
      case (s_r.tst)
        loop_pkg::T_WAIT: begin
          // [R17] alternate with far frames unless full duplex
          if (full_duplex || s_r.hgo ||
              (master && s_r.hwait == 9'(`HD_TIMEOUT_BITS - 1))) begin
            n.tst = loop_pkg::T_SYNC;
            n.tcnt = 7'h01;
            n.hgo = 1'h0;
            n.hwait = '0;
            n.tinfo = s_r.pend;
            // [R18] nothing pending sends all-zero filler
            n.tsr = s_r.pend ? s_r.tbuf : '0;
            n.pend = 1'h0;
            if (s_r.pend) n.widx = 4'h0;
            k = loop_pkg::SYM_VIOL;
          end else if (master) begin
            n.hwait = s_r.hwait + 9'h001;
          end
        end
        loop_pkg::T_SYNC: begin
          // [R1] sync opens each frame
          // [R2] sync: V V then mark for info, zero for filler
          if (s_r.tcnt == 7'h01) k = loop_pkg::SYM_VIOL;
          else if (s_r.tcnt == 7'h02 && s_r.tinfo) k = loop_pkg::SYM_MARK;
          n.tcnt = s_r.tcnt + 7'h01;
          if (s_r.tcnt == 7'(`SYNC_BITS - 1)) begin
            n.tst = loop_pkg::T_INFO;
            n.tcnt = '0;
            n.tcrc = '0;
            n.tsub = '0;
          end
        end
        loop_pkg::T_INFO: begin
          // [R19] six zeros become 0 V B 0 V B
          if (s_r.tsub != '0) begin
            k = loop_pkg::sub_sym(3'(`ZRUN) - s_r.tsub);
            n.tsub = s_r.tsub - 3'h1;
          end else if (s_r.tsr[5:0] == '0 && 7'(nbits - s_r.tcnt) >= 7'(`ZRUN)) begin
            n.tsub = 3'(`ZRUN - 1);
          end else if (s_r.tsr[0]) begin
            k = loop_pkg::SYM_MARK;
          end
          // [R5] field shifted out LSB first
          // [R4] check built over the field
          n.tcrc = loop_pkg::crc_step(s_r.tcrc, s_r.tsr[0]);
          n.tsr = s_r.tsr >> 1;
          n.tcnt = s_r.tcnt + 7'h01;
          if (s_r.tcnt == nbits - 7'h01) begin
            n.tst = loop_pkg::T_CRC;
            n.tcnt = '0;
          end
        end
        loop_pkg::T_CRC: begin
          // [R6] check sent MSB first
          if (s_r.tcrc[7]) k = loop_pkg::SYM_MARK;
          n.tcrc = {s_r.tcrc[6:0], 1'h0};
          n.tcnt = s_r.tcnt + 7'h01;
          if (s_r.tcnt == 7'(`CRC_BITS - 1)) n.tst = loop_pkg::T_WAIT;
        end
        default: n.tst = loop_pkg::T_WAIT;
      endcase
      // [R9] marks alternate, zero sends nothing
      // [R10] one line high per polarity
      e = loop_pkg::emit(k, s_r.tpol);
      {n.tpol, n.tpos, n.tneg} = e;
    end
    // [R8] receive lines sampled separately
    n.rpq = loop.rx_positive_in;
    n.rnq = loop.rx_negative_in;
    if (os) n.rph = s_r.rph + 4'h1;
    if (os && s_r.rph == 4'(`OS_PER_BIT - 1)) begin
      viol = s_r.rmark & (s_r.rmpol == s_r.rlpol);
      if (s_r.rmark) n.rlpol = s_r.rmpol;
      n.rmark = 1'h0;
      n.rvp = viol;
      case (s_r.rxs)
        loop_pkg::R_HUNT: begin
          // [R2] two violations in a row open a frame
          if (viol && s_r.rvp) begin
            n.rxs = loop_pkg::R_SYNC;
            n.rcnt = '0;
          end
        end
        loop_pkg::R_SYNC: begin
          n.rcnt = s_r.rcnt + 7'h01;
          if (s_r.rcnt == '0) n.rinfo = s_r.rmark;
          else begin
            n.rxs = loop_pkg::R_INFO;
            n.rcnt = '0;
            n.rsup = '0;
            n.rcrc = '0;
          end
        end
        loop_pkg::R_INFO: begin
          // [R19] violation blanks the rest of the group
          b = s_r.rmark & ~viol & (s_r.rsup == '0);
          if (viol && s_r.rsup == '0) n.rsup = 3'(`SUB_HOLD);
          else if (s_r.rsup != '0) n.rsup = s_r.rsup - 3'h1;
          n.rbuf[s_r.rcnt] = b;
          n.rcrc = loop_pkg::crc_step(s_r.rcrc, b);
          n.rcnt = s_r.rcnt + 7'h01;
          if (s_r.rcnt == nbits - 7'h01) begin
            n.rxs = loop_pkg::R_CRC;
            n.rcnt = '0;
          end
        end
        loop_pkg::R_CRC: begin
          chk = {s_r.rchk[6:0], s_r.rmark};
          n.rchk = chk;
          n.rcnt = s_r.rcnt + 7'h01;
          if (s_r.rcnt == 7'(`CRC_BITS - 1)) begin
            n.rxs = loop_pkg::R_HUNT;
            n.rvp = 1'h0;
            n.rxdone = 1'h1;
            // [R4] compare received check with computed
            if (s_r.rinfo && chk != s_r.rcrc) n.crc_err = 1'h1;
            if (s_r.rinfo && chk == s_r.rcrc && !s_r.dact) begin
              n.dact = 1'h1;
              n.dbuf = s_r.rbuf;
              n.didx = '0;
            end
          end
        end
        default: n.rxs = loop_pkg::R_HUNT;
      endcase
    end
    // Leading edge realigns the slot phase
    if ((loop.rx_positive_in & ~s_r.rpq) | (loop.rx_negative_in & ~s_r.rnq)) begin
      n.rph = '0;
      n.rmark = 1'h1;
      n.rmpol = loop.rx_positive_in;
    end
    // Far frame end lets half duplex send
    if (s_r.rxdone) n.hgo = 1'h1;
    // Drain a checked frame into the FIFO
    if (s_r.dact && fin_ready) begin
      n.didx = s_r.didx + 4'h1;
      if (s_r.didx == nbytes - 4'h1) n.dact = 1'h0;
    end
    // [R3] first byte MSB routes voice or data
    if (fout_ready) begin
      n.ovv = fout_valid & fout_data[9];
      n.ovd = fout_valid & ~fout_data[9];
      n.odat = fout_data[7:0];
      n.olast = fout_data[8];
    end
    n.tx_rdy = ~n.pend;
  end

  // [R21] reset idles framers and clears lines
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.tx_rdy <= 1'h1;
    end else begin
      s_r <= n;
    end
  end

  assign loop.tx_positive_out = s_r.tpos;
  assign loop.tx_negative_out = s_r.tneg;
  assign tx_ready    = s_r.tx_rdy;
  assign rx_data     = s_r.odat;
  assign rx_last     = s_r.olast;
  assign voice_valid = s_r.ovv;
  assign data_valid  = s_r.ovd;
  assign crc_error   = s_r.crc_err;
endmodule

// ===== logic/loop_peer.sv
// Peer end: far loop transceiver with whole-field user ports
`include "loop_map.svh"

module loop_peer #(
  parameter int OS_DIV = 50
) (
  input  logic         clk_sys,
  input  logic         rst_b,
  input  logic         long_field,
  loop_if.peer         loop,
  input  logic         send_valid,
  input  logic         send_info,
  input  logic [95:0]  send_field,
  output logic         send_ready,
  output logic         got_valid,
  output logic         got_info,
  output logic         got_crc_ok,
  output logic [95:0]  got_field
);
  typedef struct packed {
    logic [7:0]           cnt;
    logic [3:0]           tph;
    logic                 tpos;
    logic                 tneg;
    loop_pkg::tx_state_e  tst;
    logic [6:0]           tcnt;
    logic [95:0]          tsr;
    logic                 go;
    logic                 srdy;
    logic                 tinfo;
    logic [7:0]           tcrc;
    logic [2:0]           tsub;
    logic                 tpol;
    logic                 rpq;
    logic                 rnq;
    logic [3:0]           rph;
    logic                 rmark;
    logic                 rmpol;
    logic                 rlpol;
    logic                 rvp;
    loop_pkg::rx_state_e  rxs;
    logic [6:0]           rcnt;
    logic [2:0]           rsup;
    logic                 rinfo;
    logic [95:0]          rbuf;
    logic [7:0]           rcrc;
    logic [7:0]           rchk;
    logic                 gv;
    logic                 gi;
    logic                 gok;
  } st_s;

  st_s             s_r;
  st_s             n;
  logic [6:0]      nbits;
  logic            os;
  logic            viol;
  logic            b;
  logic [7:0]      chk;
  loop_pkg::sym_e  k;

  // Same framing and line code as the device end
  always_comb begin
    n = s_r;
    n.gv = 1'h0;
    k = loop_pkg::SYM_ZERO;
    b = 1'h0;
    viol = 1'h0;
    chk = '0;
    nbits = long_field ? 7'(`LONG_BYTES * 8) : 7'(`SHORT_BYTES * 8);
    // [R13] own 16x tick is clk_sys divided by OS_DIV, with no 4.096 MHz limit applied
    os = (s_r.cnt == '0);
    n.cnt = os ? 8'(OS_DIV - 1) : s_r.cnt - 8'h01;
    if (send_valid && s_r.srdy) begin
      n.tsr = send_field;
      n.tinfo = send_info;
      n.go = 1'h1;
      n.srdy = 1'h0;
    end
    // [R15] pulses held half a bit
    if (os) begin
      n.tph = s_r.tph + 4'h1;
      if (s_r.tph == 4'(`PULSE_OS - 1)) {n.tpos, n.tneg} = 2'h0;
    end
    // [R16] rising edges on whole bit slots
    if (os && s_r.tph == 4'(`OS_PER_BIT - 1)) begin
      case (s_r.tst)
        loop_pkg::T_WAIT: begin
          if (s_r.go) begin
            n.tst = loop_pkg::T_SYNC;
            n.tcnt = 7'h01;
            n.go = 1'h0;
            k = loop_pkg::SYM_VIOL;
          end
        end
        loop_pkg::T_SYNC: begin
          // [R1] sync precedes the field
          if (s_r.tcnt == 7'h01) k = loop_pkg::SYM_VIOL;
          else if (s_r.tcnt == 7'h02 && s_r.tinfo) k = loop_pkg::SYM_MARK;
          n.tcnt = s_r.tcnt + 7'h01;
          if (s_r.tcnt == 7'(`SYNC_BITS - 1)) begin
            n.tst = loop_pkg::T_INFO;
            n.tcnt = '0;
            n.tcrc = '0;
            n.tsub = '0;
          end
        end
        loop_pkg::T_INFO: begin
          // [R19] zero runs substituted
          if (s_r.tsub != '0) begin
            k = loop_pkg::sub_sym(3'(`ZRUN) - s_r.tsub);
            n.tsub = s_r.tsub - 3'h1;
          end else if (s_r.tsr[5:0] == '0 && 7'(nbits - s_r.tcnt) >= 7'(`ZRUN)) begin
            n.tsub = 3'(`ZRUN - 1);
          end else if (s_r.tsr[0]) begin
            k = loop_pkg::SYM_MARK;
          end
          // [R5] LSB first, check accumulated
          n.tcrc = loop_pkg::crc_step(s_r.tcrc, s_r.tsr[0]);
          n.tsr = s_r.tsr >> 1;
          n.tcnt = s_r.tcnt + 7'h01;
          if (s_r.tcnt == nbits - 7'h01) begin
            n.tst = loop_pkg::T_CRC;
            n.tcnt = '0;
          end
        end
        loop_pkg::T_CRC: begin
          // [R6] check MSB first
          if (s_r.tcrc[7]) k = loop_pkg::SYM_MARK;
          n.tcrc = {s_r.tcrc[6:0], 1'h0};
          n.tcnt = s_r.tcnt + 7'h01;
          if (s_r.tcnt == 7'(`CRC_BITS - 1)) begin
            n.tst = loop_pkg::T_WAIT;
            n.srdy = 1'h1;
          end
        end
        default: n.tst = loop_pkg::T_WAIT;
      endcase
      // [R10] polarity pair coding
      {n.tpol, n.tpos, n.tneg} = loop_pkg::emit(k, s_r.tpol);
    end
    // Receive side decode
    n.rpq = loop.tx_positive_out;
    n.rnq = loop.tx_negative_out;
    if (os) n.rph = s_r.rph + 4'h1;
    if (os && s_r.rph == 4'(`OS_PER_BIT - 1)) begin
      viol = s_r.rmark & (s_r.rmpol == s_r.rlpol);
      if (s_r.rmark) n.rlpol = s_r.rmpol;
      n.rmark = 1'h0;
      n.rvp = viol;
      case (s_r.rxs)
        loop_pkg::R_HUNT: begin
          if (viol && s_r.rvp) begin
            n.rxs = loop_pkg::R_SYNC;
            n.rcnt = '0;
          end
        end
        loop_pkg::R_SYNC: begin
          n.rcnt = s_r.rcnt + 7'h01;
          if (s_r.rcnt == '0) n.rinfo = s_r.rmark;
          else begin
            n.rxs = loop_pkg::R_INFO;
            n.rcnt = '0;
            n.rsup = '0;
            n.rcrc = '0;
          end
        end
        loop_pkg::R_INFO: begin
          b = s_r.rmark & ~viol & (s_r.rsup == '0);
          if (viol && s_r.rsup == '0) n.rsup = 3'(`SUB_HOLD);
          else if (s_r.rsup != '0) n.rsup = s_r.rsup - 3'h1;
          n.rbuf[s_r.rcnt] = b;
          n.rcrc = loop_pkg::crc_step(s_r.rcrc, b);
          n.rcnt = s_r.rcnt + 7'h01;
          if (s_r.rcnt == nbits - 7'h01) begin
            n.rxs = loop_pkg::R_CRC;
            n.rcnt = '0;
          end
        end
        loop_pkg::R_CRC: begin
          // [R4] check verified
          chk = {s_r.rchk[6:0], s_r.rmark};
          n.rchk = chk;
          n.rcnt = s_r.rcnt + 7'h01;
          if (s_r.rcnt == 7'(`CRC_BITS - 1)) begin
            n.rxs = loop_pkg::R_HUNT;
            n.rvp = 1'h0;
            n.gv = 1'h1;
            // [R3] voice flag read by the user from bit 7
            n.gi = s_r.rinfo;
            n.gok = (chk == s_r.rcrc);
          end
        end
        default: n.rxs = loop_pkg::R_HUNT;
      endcase
    end
    if ((loop.tx_positive_out & ~s_r.rpq) | (loop.tx_negative_out & ~s_r.rnq)) begin
      n.rph = '0;
      n.rmark = 1'h1;
      n.rmpol = loop.tx_positive_out;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.srdy <= 1'h1;
    end else begin
      s_r <= n;
    end
  end

  assign loop.rx_positive_in = s_r.tpos;
  assign loop.rx_negative_in = s_r.tneg;
  assign send_ready = s_r.srdy;
  assign got_valid  = s_r.gv;
  assign got_info   = s_r.gi;
  assign got_crc_ok = s_r.gok;
  assign got_field  = s_r.rbuf;
endmodule

// ===== bench/loop_asserts.sv
// Wire checks on the loop between device and peer ends
module loop_asserts #(
  parameter int PULSE = 32
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic tx_positive_out,
  input wire logic tx_negative_out,
  input wire logic rx_positive_in,
  input wire logic rx_negative_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] wp_r, wn_r, wr_r, gt_r, gr_r;
  // Pulse widths and rising-edge gaps in clk cycles
  always_ff @(posedge clk_sys) begin
    wp_r <= tx_positive_out ? wp_r + 8'h01 : 8'h00;
    wn_r <= tx_negative_out ? wn_r + 8'h01 : 8'h00;
    wr_r <= (rx_positive_in | rx_negative_in) ? wr_r + 8'h01 : 8'h00;
    gt_r <= ($rose(tx_positive_out) || $rose(tx_negative_out)) ? 8'h01 : gt_r + {7'h0, ~&gt_r};
    gr_r <= ($rose(rx_positive_in) || $rose(rx_negative_in)) ? 8'h01 : gr_r + {7'h0, ~&gr_r};
    if (!rst_b) begin
      gt_r <= 8'hFF;
      gr_r <= 8'hFF;
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_tx_lines_exclusive: assert property (!(tx_positive_out && tx_negative_out))
    else $error("tx lines both high");
  a_rx_lines_exclusive: assert property (!(rx_positive_in && rx_negative_in))
    else $error("rx lines both high");
  a_tx_pos_width: assert property ($fell(tx_positive_out) |-> wp_r == PULSE[7:0])
    else $error("tx positive width wrong");
  a_tx_neg_width: assert property ($fell(tx_negative_out) |-> wn_r == PULSE[7:0])
    else $error("tx negative width wrong");
  // Six to twenty ticks of four clocks
  a_rx_pulse_width: assert property (
    $fell(rx_positive_in | rx_negative_in) |-> wr_r inside {[8'h18:8'h50]})
    else $error("rx pulse width out of range");
  a_rx_edge_gap: assert property (
    $rose(rx_positive_in) || $rose(rx_negative_in) |-> gr_r >= 8'h28)
    else $error("rx edges too close");
  a_tx_slot_gap: assert property (
    $rose(tx_positive_out) || $rose(tx_negative_out) |-> gt_r >= 2 * PULSE)
    else $error("tx marks closer than a slot");
  a_reset_lines_low: assert property (
    disable iff (1'h0) !rst_b |=> !tx_positive_out && !tx_negative_out)
    else $error("tx lines not low in reset");
  c_tx_pos: cover property ($rose(tx_positive_out));
  c_tx_neg: cover property ($rose(tx_negative_out));
  c_rx_mark: cover property ($rose(rx_positive_in) || $rose(rx_negative_in));
endmodule

// ===== bench/tb.sv
// Testbench joining device and peer loop ends back to back
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'h0, rst_b = 1'h0, long_field = 1'h0, tx_valid = 1'h0;
  logic        voice_ready = 1'h0, data_ready = 1'h0, send_valid = 1'h0, send_info = 1'h0;
  logic [1:0]  bc = 2'h0;
  logic [7:0]  tx_data = 8'h00, rx_data;
  logic [95:0] send_field = 96'h0, got_field;
  logic [31:0] seed = 32'h5C, rr;
  logic        tx_ready, rx_last, voice_valid, data_valid, crc_error;
  logic        send_ready, got_valid, got_info, got_crc_ok;
  logic [96:0] qf[$];
  logic [8:0]  qv[$], qd[$];
  int          errors = 0, n_checks = 0, cyc = 0;
  loop_if u_loop_if ();
  loop_transceiver u_loop_transceiver (.clk_sys, .rst_b,
    .baud_clock_in(bc[1]), .rate_sel(2'h3), .long_field, .full_duplex(1'h1), .master(long_field),
    .loop(u_loop_if.device), .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_last,
    .voice_valid, .voice_ready, .data_valid, .data_ready, .crc_error);
  loop_peer #(.OS_DIV(4)) u_loop_peer (.clk_sys, .rst_b, .long_field,
    .loop(u_loop_if.peer), .send_valid, .send_info, .send_field, .send_ready,
    .got_valid, .got_info, .got_crc_ok, .got_field);
  loop_asserts u_loop_asserts (.clk_sys, .rst_b,
    .tx_positive_out(u_loop_if.tx_positive_out), .tx_negative_out(u_loop_if.tx_negative_out),
    .rx_positive_in(u_loop_if.rx_positive_in), .rx_negative_in(u_loop_if.rx_negative_in));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int nb();
    return long_field ? 12 : 10;
  endfunction
  function automatic logic [95:0] msk();
    return {{16{long_field}}, {80{1'h1}}};
  endfunction
  // Random field with a zero run; byte 0 bit 7 picks the port
  function automatic logic [95:0] rf(input logic voice);
    logic [95:0] f;
    f = {xs(), xs(), xs()};
    f[15:8] = 8'h00;
    f[7] = voice;
    return f & msk();
  endfunction
  task automatic cmp(input logic [96:0] got, input logic [96:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Device user side: bytes held until taken
  task automatic dev_send(input logic [95:0] f);
    qf.push_back({1'h1, f});
    for (int i = 0; i < nb(); i++) begin
      tx_data = f[8*i +: 8];
      tx_valid = 1'h1;
      while (tx_ready !== 1'h1) @(posedge clk_sys) #1;
      @(posedge clk_sys) #1;
    end
    tx_valid = 1'h0;
    @(posedge clk_sys) #1;
  endtask
  // Peer sends a frame; info frames expected on one port
  task automatic peer_send(input logic info, input logic [95:0] f);
    for (int k = 0; k < nb() && info; k++)
      if (f[7]) qv.push_back({k == nb() - 1, f[8*k +: 8]});
      else qd.push_back({k == nb() - 1, f[8*k +: 8]});
    {send_info, send_field, send_valid} = {info, f, 1'h1};
    while (send_ready !== 1'h1) @(posedge clk_sys) #1;
    @(posedge clk_sys) #1;
    send_valid = 1'h0;
    @(posedge clk_sys) #1;
  endtask
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // 16x tick every 4 clocks at both ends, port stalls, hang guard
  always @(posedge clk_sys) begin
    #1;
    bc = bc + 2'h1;
    rr = xs();
    voice_ready = |rr[1:0];
    data_ready = |rr[3:2];
    cyc++;
    if (cyc == 90000) begin
      errors++;
      complete_run();
    end
  end
  always @(negedge clk_sys) if (rst_b) begin
    if (voice_valid && voice_ready) cmp({rx_last, rx_data}, qv.size() ? qv.pop_front() : 'x);
    if (data_valid && data_ready) cmp({rx_last, rx_data}, qd.size() ? qd.pop_front() : 'x);
    if (crc_error) cmp(1'h1, 1'h0);
    if (got_valid) cmp({got_crc_ok, got_field & msk()},
      got_info ? (qf.size() ? qf.pop_front() : 'x) : {1'h1, 96'h0});
  end
  initial begin
    for (int lf = 0; lf < 2; lf++) begin
      #1 rst_b = 1'h0;
      long_field = lf[0];
      repeat (16) @(posedge clk_sys);
      #1 rst_b = 1'h1;
      fork
        begin
          dev_send(rf(1));
          dev_send(rf(0));
          dev_send(rf(1));
        end
        begin
          peer_send(1'h0, rf(0));
          peer_send(1'h1, rf(1));
          peer_send(1'h1, rf(0));
        end
      join
      while (qf.size() || qv.size() || qd.size()) @(posedge clk_sys);
      $display("Test with %0d-byte field done, errors %0d", nb(), errors);
    end
    complete_run();
  end
endmodule
